// *** rtl/sae_pkg.sv ***
/*
  Constants, register map and types of the setpoint alarm engine.
  Assumes a 25 MHz pclk and a 32-bit APB master.
*/
package sae_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CYCLE_S = 1;
  localparam int TICK_CYC = CYCLE_S * CLK_HZ;
  localparam int NDIN = 4;
  localparam int NPH = 3;
  localparam int DLY_W = 8;
  localparam int VAL_W = 16;
  localparam int NSRC = 9;
  localparam logic [2:0] CHAT_1S_MAX = 3'h4;
  localparam logic [3:0] CHAT_10S_MAX = 4'ha;
  localparam logic [3:0] CHAT_WIN_TICKS = 4'ha;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DELAY = 8'h04;
  localparam logic [7:0] A_PU_SP = 8'h08;
  localparam logic [7:0] A_DO_SP = 8'h0c;
  localparam logic [7:0] A_ACTMAP = 8'h10;
  localparam logic [7:0] A_PRIO = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_START_TS = 8'h1c;
  localparam logic [7:0] A_END_TS = 8'h20;
  localparam logic [7:0] A_DUR = 8'h24;
  localparam logic [7:0] A_PEAK1 = 8'h28;
  localparam logic [7:0] A_PEAK2 = 8'h2c;
  localparam logic [7:0] A_LOG = 8'h30;
  localparam logic [7:0] A_TIME = 8'h34;
  localparam int CTRL_UNDER = 4;
  localparam int CTRL_EROT = 5;
  localparam int CTRL_STD_EN = 6;
  localparam int ST_STD = 4;
  localparam int ST_DIS = 8;
  localparam int ST_UN = 16;
  localparam int LOG_END = 4;
  localparam int LOG_PRIO = 5;
  localparam int LOG_CNT = 16;
  localparam int SRC_STD = 4;
  localparam int SRC_UN = 5;
  localparam logic [31:0] CTRL_RST = 32'h0000000f;
  localparam logic [31:0] PRIO_RST = 32'h00015555;
  typedef enum logic [1:0] {UN_PWRUP = 2'b00, UN_RESET = 2'b01, UN_DIAG = 2'b10,
                            UN_PREV = 2'b11} sae_unary_t;
  typedef enum logic [1:0] {PR_LOW = 2'b00, PR_MED = 2'b01, PR_HIGH = 2'b10} sae_prio_t;
  typedef enum logic {QS_IDLE = 1'b0, QS_ALARM = 1'b1} sae_qst_t;
endpackage

// *** rtl/sae_qual.sv ***
/*
  Pickup and dropout delay qualifier for one alarm condition.
  Assumes tick pulses once per second on pclk.
*/
`timescale 1ns/1ps
module sae_qual
  import sae_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Owner side.
  sae_qual_if.qual q
);
  sae_qst_t st_ff;
  sae_qst_t nxt_st;
  logic [DLY_W-1:0] cnt_ff;
  logic [DLY_W-1:0] nxt_cnt;
  logic cond;
  logic [DLY_W-1:0] dly;
  logic [DLY_W-1:0] inc;

  assign cond = (st_ff == QS_IDLE) ? q.pick : q.drop;
  assign dly = (st_ff == QS_IDLE) ? q.pu_dly : q.do_dly;
  assign inc = q.tick ? DLY_W'(cnt_ff + 1'b1) : cnt_ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = '0;
    case (st_ff)
      QS_IDLE: begin
        if (cond && !q.clr) begin
          if (inc >= q.pu_dly) nxt_st = QS_ALARM;
          else nxt_cnt = inc;
        end
      end
      QS_ALARM: begin
        if (q.clr) nxt_st = QS_IDLE;
        else if (cond) begin
          if (inc >= q.do_dly) nxt_st = QS_IDLE;
          else nxt_cnt = inc;
        end
      end
      default: nxt_st = QS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= QS_IDLE;
      cnt_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  assign q.active = (st_ff == QS_ALARM);
  assign q.rise = (st_ff == QS_IDLE) && (nxt_st == QS_ALARM);
  assign q.fall = (st_ff == QS_ALARM) && (nxt_st == QS_IDLE);

  lapse_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cond |=> cnt_ff == '0 && st_ff == $past(st_ff) || $past(q.clr))
    else $error("delay count not restarted");
  pickup_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_ff == QS_ALARM) && !$past(q.clr) |-> $past(inc) >= $past(dly))
    else $error("alarm changed before its delay");
endmodule // sae_qual

// *** rtl/sae_qual_if.sv ***
/*
  Carrier between the engine and one delay qualifier.
  Assumes one owner drives conditions and reads the state.
*/
`timescale 1ns/1ps
interface sae_qual_if;
  import sae_pkg::*;
  logic pick;
  logic drop;
  logic tick;
  logic clr;
  logic [DLY_W-1:0] pu_dly;
  logic [DLY_W-1:0] do_dly;
  logic active;
  logic rise;
  logic fall;
  modport qual (input pick, drop, tick, clr, pu_dly, do_dly, output active, rise, fall);
  modport owner (output pick, drop, tick, clr, pu_dly, do_dly, input active, rise, fall);
endinterface

// *** rtl/sae_top.sv ***
/*
  Setpoint alarm engine: unary, digital input and one three-phase
  over or under standard alarm, with an APB register file.
  Assumes phase values and status flags come from logic on pclk and
  digital inputs and the cold-boot flag come from pins.
*/
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module sae_top
  import sae_pkg::*;
#(
  parameter int TICK_N = TICK_CYC,
  parameter int N_DIN = NDIN
)(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Digital status inputs and supervisor flags.
  input wire logic [N_DIN-1:0] din,
  input wire logic cold_boot,
  // Measurement front end.
  input wire logic [NPH*VAL_W-1:0] phase_val,
  input wire logic rot_obs,
  input wire logic diag_fault,
  // Alarm action output.
  output logic alarm_dout
);
  function automatic logic better(input logic under, input logic [VAL_W-1:0] a,
                                  input logic [VAL_W-1:0] b);
    better = under ? (a < b) : (a > b);
  endfunction

  function automatic logic [3:0] first_idx(input logic [NSRC-1:0] v);
    first_idx = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) first_idx = 4'(i);
    end
  endfunction

  logic [31:0] ctrl_ff, delay_ff, pu_sp_ff, do_sp_ff, actmap_ff, prio_ff;
  logic [31:0] start_ts_ff, end_ts_ff, dur_ff, rtc_ff, log_ff;
  logic [VAL_W-1:0] peak1_ff, peak2_ff;
  logic [31:0] prdata_ff, rd_mux;
  logic pready_ff, pslverr_ff, dout_ff;
  logic [31:0] tcnt_ff;
  logic tick_ff;
  logic [3:0] win_ff;
  logic [N_DIN-1:0] din_m_ff, din_s_ff, din_d_ff, dis_ff;
  logic cold_m_ff, cold_s_ff;
  logic [2:0] rst_sh_ff;
  logic diag_d_ff, rev_d_ff, std_act_ff;
  logic [3:0] un_ff;
  logic [3:0] un_ev;
  logic [NPH-1:0] ph_act, ph_rise, ph_pick;
  logic [N_DIN-1:0] din_act, din_rise, din_fall, chat;
  logic [NSRC-1:0] ev_start, ev_end, src_act;
  logic std_start, std_end, under, rev_now, map_hit, wr_en, rd_en, mapped;
  logic [VAL_W-1:0] cur;
  logic [7:0] addr;
  logic [31:0] w1c_st;

  // APB: one wait state, answer in the second access cycle.
  assign addr = paddr[7:0];
  assign mapped = (paddr[31:8] == '0) && (addr[1:0] == 2'b00) && (addr <= A_TIME);
  assign wr_en = psel && penable && pready_ff && pwrite && mapped;
  assign rd_en = psel && penable && !pready_ff;
  assign w1c_st = (wr_en && addr == A_STATUS) ? pwdata : '0;
  assign under = ctrl_ff[CTRL_UNDER];

  always_comb begin
    case (addr)
      A_CTRL: rd_mux = ctrl_ff;
      A_DELAY: rd_mux = delay_ff;
      A_PU_SP: rd_mux = pu_sp_ff;
      A_DO_SP: rd_mux = do_sp_ff;
      A_ACTMAP: rd_mux = actmap_ff;
      A_PRIO: rd_mux = prio_ff;
      A_STATUS: rd_mux = 32'(un_ff) << ST_UN | 32'(dis_ff) << ST_DIS
                         | 32'(std_act_ff) << ST_STD | 32'(din_act);
      A_START_TS: rd_mux = start_ts_ff;
      A_END_TS: rd_mux = end_ts_ff;
      A_DUR: rd_mux = dur_ff;
      A_PEAK1: rd_mux = 32'(peak1_ff);
      A_PEAK2: rd_mux = 32'(peak2_ff);
      A_LOG: rd_mux = log_ff;
      A_TIME: rd_mux = rtc_ff;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= rd_en;
      pslverr_ff <= rd_en && !mapped;
      if (rd_en && !pwrite) prdata_ff <= mapped ? rd_mux : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
      delay_ff <= '0;
      pu_sp_ff <= '0;
      do_sp_ff <= '0;
      actmap_ff <= '0;
      prio_ff <= PRIO_RST;
    end else if (wr_en) begin
      if (addr == A_CTRL) ctrl_ff <= pwdata;
      if (addr == A_DELAY) delay_ff <= pwdata;
      if (addr == A_PU_SP) pu_sp_ff <= pwdata;
      if (addr == A_DO_SP) do_sp_ff <= pwdata;
      if (addr == A_ACTMAP) actmap_ff <= pwdata;
      if (addr == A_PRIO) prio_ff <= pwdata;
    end
  end

  // One-second metering tick and seconds counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt_ff <= '0;
      tick_ff <= 1'b0;
      rtc_ff <= '0;
      win_ff <= '0;
    end else begin
      tick_ff <= (tcnt_ff == 32'(TICK_N - 1));
      tcnt_ff <= (tcnt_ff == 32'(TICK_N - 1)) ? '0 : tcnt_ff + 1'b1;
      if (tick_ff) begin
        rtc_ff <= rtc_ff + 1'b1;
        win_ff <= (win_ff == CHAT_WIN_TICKS - 1'b1) ? '0 : win_ff + 1'b1;
      end
    end
  end

  // Unary alarms, each a sticky bit cleared by writing one; a set wins.
  assign rev_now = rot_obs != ctrl_ff[CTRL_EROT];
  assign un_ev[UN_RESET] = rst_sh_ff[0] && !rst_sh_ff[1];
  assign un_ev[UN_PWRUP] = rst_sh_ff[1] && !rst_sh_ff[2] && cold_s_ff;
  assign un_ev[UN_DIAG] = diag_fault && !diag_d_ff;
  assign un_ev[UN_PREV] = rev_now && !rev_d_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sh_ff <= '0;
      cold_m_ff <= 1'b0;
      cold_s_ff <= 1'b0;
      diag_d_ff <= 1'b0;
      rev_d_ff <= 1'b0;
      un_ff <= '0;
    end else begin
      rst_sh_ff <= {rst_sh_ff[1:0], 1'b1};
      cold_m_ff <= cold_boot;
      cold_s_ff <= cold_m_ff;
      diag_d_ff <= diag_fault;
      rev_d_ff <= rev_now;
      un_ff <= (un_ff & ~w1c_st[ST_UN +: 4]) | un_ev;
    end
  end

  // Digital input alarms with chatter lockout.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_m_ff <= '0;
      din_s_ff <= '0;
      din_d_ff <= '0;
      dis_ff <= '0;
    end else begin
      din_m_ff <= din;
      din_s_ff <= din_m_ff;
      din_d_ff <= din_s_ff;
      dis_ff <= (dis_ff & ~w1c_st[ST_DIS +: N_DIN]) | chat;
    end
  end

  for (genvar i = 0; i < N_DIN; i++) begin : g_din
    logic [2:0] t1_ff;
    logic [3:0] t10_ff;
    logic tog;
    sae_qual_if qi ();
    assign tog = din_s_ff[i] ^ din_d_ff[i];
    // Only a toggle at or past a count limit disables, so a re-enable sticks
    // while the input stays quiet.
    assign chat[i] = tog && ((t1_ff >= CHAT_1S_MAX) || (t10_ff >= CHAT_10S_MAX));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        t1_ff <= '0;
        t10_ff <= '0;
      end else begin
        if (tick_ff) t1_ff <= '0;
        else if (tog && t1_ff <= CHAT_1S_MAX) t1_ff <= t1_ff + 1'b1;
        if (tick_ff && win_ff == CHAT_WIN_TICKS - 1'b1) t10_ff <= '0;
        else if (tog && t10_ff <= CHAT_10S_MAX) t10_ff <= t10_ff + 1'b1;
      end
    end
    assign qi.pick = din_s_ff[i];
    assign qi.drop = !din_s_ff[i];
    assign qi.tick = tick_ff;
    assign qi.clr = !ctrl_ff[i] || dis_ff[i];
    assign qi.pu_dly = delay_ff[0 +: DLY_W];
    assign qi.do_dly = delay_ff[DLY_W +: DLY_W];
    assign din_act[i] = qi.active;
    assign din_rise[i] = qi.rise;
    assign din_fall[i] = qi.fall;
    sae_qual u_q (.pclk(pclk), .presetn(presetn), .q(qi));
  end

  // Standard alarm: each phase qualified on its own, reported as one.
  for (genvar p = 0; p < NPH; p++) begin : g_ph
    logic [VAL_W-1:0] v;
    sae_qual_if qp ();
    assign v = phase_val[p*VAL_W +: VAL_W];
    assign qp.pick = better(under, v, pu_sp_ff[VAL_W-1:0]);
    assign qp.drop = better(!under, v, do_sp_ff[VAL_W-1:0]);
    assign qp.tick = tick_ff;
    // The standard alarm has its own enable, so over mode can run too.
    assign qp.clr = !ctrl_ff[CTRL_STD_EN];
    assign qp.pu_dly = delay_ff[2*DLY_W +: DLY_W];
    assign qp.do_dly = delay_ff[3*DLY_W +: DLY_W];
    assign ph_act[p] = qp.active;
    assign ph_rise[p] = qp.rise;
    assign ph_pick[p] = qp.pick;
    sae_qual u_q (.pclk(pclk), .presetn(presetn), .q(qp));
  end

  // Start is the one cycle in which a phase is active and the report is not yet.
  assign std_start = !std_act_ff && (|ph_act);
  assign std_end = std_act_ff && !(|ph_act);
  assign cur = better(under, phase_val[VAL_W +: VAL_W], phase_val[0 +: VAL_W])
    ? (better(under, phase_val[2*VAL_W +: VAL_W], phase_val[VAL_W +: VAL_W])
       ? phase_val[2*VAL_W +: VAL_W] : phase_val[VAL_W +: VAL_W])
    : (better(under, phase_val[2*VAL_W +: VAL_W], phase_val[0 +: VAL_W])
       ? phase_val[2*VAL_W +: VAL_W] : phase_val[0 +: VAL_W]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      std_act_ff <= 1'b0;
      start_ts_ff <= '0;
      end_ts_ff <= '0;
      dur_ff <= '0;
      peak1_ff <= '0;
      peak2_ff <= '0;
    end else begin
      std_act_ff <= |ph_act;
      if (std_start) start_ts_ff <= rtc_ff;
      if (std_end) begin
        end_ts_ff <= rtc_ff;
        dur_ff <= rtc_ff - start_ts_ff;
      end
      // Peak one follows the value until a phase starts to qualify, then keeps the extreme.
      if (!std_act_ff && !(|ph_pick)) peak1_ff <= cur;
      else if (!std_act_ff && better(under, cur, peak1_ff)) peak1_ff <= cur;
      if (std_start) peak2_ff <= cur;
      else if (std_act_ff && better(under, cur, peak2_ff)) peak2_ff <= cur;
    end
  end

  // Event log and action output.
  assign ev_start = {un_ev, std_start, 4'(din_rise)};
  assign ev_end = {4'b0000, std_end, 4'(din_fall)};
  assign src_act = {un_ff, std_act_ff, 4'(din_act)};
  assign map_hit = |(actmap_ff[NSRC-1:0] & src_act);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_ff <= '0;
      dout_ff <= 1'b0;
    end else begin
      dout_ff <= map_hit;
      if (|ev_start || |ev_end) begin
        log_ff[3:0] <= first_idx(ev_start | ev_end);
        log_ff[LOG_END] <= !(|ev_start);
        log_ff[LOG_PRIO +: 2] <= prio_ff[2*first_idx(ev_start | ev_end) +: 2];
        log_ff[LOG_CNT +: 16] <= log_ff[LOG_CNT +: 16] + 1'b1;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign alarm_dout = dout_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rot_rev_a: assert property ($rose(rev_now) |=> un_ff[UN_PREV])
    else $error("phase reversal not flagged");
  chat_lock_a: assert property (chat[0] |=> dis_ff[0])
    else $error("chatter did not disable input alarm");
  dis_hold_a: assert property (dis_ff[0] && !w1c_st[ST_DIS] |=> dis_ff[0])
    else $error("disabled input alarm re-enabled itself");
  std_any_a: assert property (|ph_act |=> std_act_ff)
    else $error("standard alarm inactive with a phase in alarm");
  std_drop_a: assert property ($fell(std_act_ff) |-> $past(ph_act) == '0)
    else $error("standard alarm dropped with phase still active");
  ts_start_a: assert property (std_start |=> start_ts_ff == $past(rtc_ff))
    else $error("start timestamp wrong");
  dur_calc_a: assert property (std_end |=> dur_ff == end_ts_ff - start_ts_ff)
    else $error("alarm duration wrong");
  peak_keep_a: assert property (std_act_ff && !std_start && !under |=>
    peak2_ff >= $past(peak2_ff))
    else $error("peak value decreased");
  action_out_a: assert property (map_hit |=> alarm_dout)
    else $error("assigned output not driven");
  log_count_a: assert property (|ev_start |=>
    log_ff[LOG_CNT +: 16] == $past(log_ff[LOG_CNT +: 16]) + 16'h0001)
    else $error("event not logged");
  tick_gap_a: assert property (tick_ff |=> !tick_ff)
    else $error("metering tick too frequent");
  pick_start_a: assert property (|ph_rise && !(|ph_act) |=> std_start)
    else $error("first phase pickup did not start the alarm");
  start_once_a: assert property (std_start |=> std_act_ff && !std_start)
    else $error("alarm start reported twice");
  end_once_a: assert property (std_end |=> !std_end && !std_act_ff)
    else $error("alarm end reported twice");
  end_ts_a: assert property (std_end |=> end_ts_ff == $past(rtc_ff))
    else $error("end timestamp wrong");
  low_keep_a: assert property (std_act_ff && !std_start && under |=>
    peak2_ff <= $past(peak2_ff))
    else $error("lowest value increased");
  dis_gate_a: assert property (dis_ff[0] |-> !din_rise[0])
    else $error("disabled input alarm picked up");
  unary_set_a: assert property (|un_ev |=>
    (un_ff & $past(un_ev)) == $past(un_ev))
    else $error("unary event not flagged");
  unary_keep_a: assert property (un_ff[UN_DIAG] && !w1c_st[ST_UN + int'(UN_DIAG)] |=>
    un_ff[UN_DIAG])
    else $error("unary flag lost without a clear");
  dout_clr_a: assert property (!map_hit |=> !alarm_dout)
    else $error("output driven with no mapped alarm");
  std_gate_a: assert property (!ctrl_ff[CTRL_STD_EN] ##1 !ctrl_ff[CTRL_STD_EN] |=>
    !std_act_ff)
    else $error("disabled standard alarm still active");
endmodule // sae_top

// *** verification/sae_meas_model.sv ***
/*
  Model of the measurement front end and the digital status pins.
  Assumes the bench sets the wanted levels; outputs follow one pclk later.
*/
`timescale 1ns/1ps
module sae_meas_model
  import sae_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Wanted levels from the bench.
  input wire logic [NPH*VAL_W-1:0] ph_set,
  input wire logic [NDIN-1:0] din_set,
  input wire logic rot_set,
  input wire logic diag_set,
  // Levels seen by the engine.
  output logic [NPH*VAL_W-1:0] phase_val,
  output logic [NDIN-1:0] din,
  output logic rot_obs,
  output logic diag_fault
);
  // Values refresh once per clock, like a sampled metering path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_val <= '0;
      din <= '0;
      rot_obs <= 1'b0;
      diag_fault <= 1'b0;
    end else begin
      phase_val <= ph_set;
      din <= din_set;
      rot_obs <= rot_set;
      diag_fault <= diag_set;
    end
  end
endmodule // sae_meas_model

// *** verification/testbench.sv ***
/*
  Self-checking bench for the setpoint alarm engine over APB.
  Assumes a short second tick of 20 pclk cycles.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import sae_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cold_boot;
  logic [31:0] paddr, pwdata, prdata, rd, s, e, d;
  logic err, rot_obs, diag_fault, rot_set, diag_set, alarm_dout;
  logic [3:0] din, din_set;
  logic [47:0] phase_val, ph_set;
  int failures = 0;
  int checks = 0;

  sae_top #(.TICK_N(20), .N_DIN(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .din(din), .cold_boot(cold_boot),
    .phase_val(phase_val), .rot_obs(rot_obs), .diag_fault(diag_fault),
    .alarm_dout(alarm_dout));

  sae_meas_model meas_u (.pclk(pclk), .presetn(presetn), .ph_set(ph_set),
    .din_set(din_set), .rot_set(rot_set), .diag_set(diag_set), .phase_val(phase_val),
    .din(din), .rot_obs(rot_obs), .diag_fault(diag_fault));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) failures++;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, rd, err);
  endtask

  task automatic chk(input string nm, input logic [31:0] a, input logic [31:0] m,
                     input logic [31:0] ex);
    apb(1'b0, a, 32'h0, rd, err);
    `CHK(nm, ex, rd & m)
  endtask

  // Polls status until the masked field matches, bounded by a read count.
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, {24'h0, A_STATUS}, 32'h0, rd, err);
      n++;
    end while ((rd & m) !== v && n < 60);
    `CHK("status", v, rd & m)
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    stop_test;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    cold_boot = 1'b1;
    ph_set = {3{16'h01f4}};
    din_set = 4'h0;
    rot_set = 1'b0;
    diag_set = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("ctrl", {24'h0, A_CTRL}, 32'hffffffff, CTRL_RST);
    chk("prio", {24'h0, A_PRIO}, 32'hffffffff, PRIO_RST);
    wait_st(32'hf0000, 32'h30000);
    apb(1'b0, 32'h38, 32'h0, rd, err);
    `CHK("bad_err", 1'b1, err)
    `CHK("bad_rd", 32'h0, rd)
    wr({24'h0, A_STATUS}, 32'h30000);
    chk("un_clr", {24'h0, A_STATUS}, 32'hf0000, 32'h0);
    rot_set <= 1'b1;
    wait_st(32'h80000, 32'h80000);
    wr({24'h0, A_CTRL}, 32'h2f);
    wr({24'h0, A_STATUS}, 32'h80000);
    chk("rot_ok", {24'h0, A_STATUS}, 32'h80000, 32'h0);
    diag_set <= 1'b1;
    wait_st(32'h40000, 32'h40000);
    // Input pickup 3 s, input dropout 2 s, standard pickup and dropout 2 s.
    wr({24'h0, A_DELAY}, 32'h02020203);
    wr({24'h0, A_ACTMAP}, 32'h1);
    din_set <= 4'h1;
    chk("in_early", {24'h0, A_STATUS}, 32'h1, 32'h0);
    wait_st(32'h1, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("dout_on", 1'b1, alarm_dout)
    chk("log_on", {24'h0, A_LOG}, 32'h7f, 32'h20);
    din_set <= 4'h0;
    wait_st(32'h1, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK("dout_off", 1'b0, alarm_dout)
    chk("log_off", {24'h0, A_LOG}, 32'h7f, 32'h30);
    // A short dip must restart the pickup count.
    din_set <= 4'h4;
    repeat (30) @(posedge pclk);
    din_set <= 4'h0;
    repeat (5) @(posedge pclk);
    din_set <= 4'h4;
    repeat (35) @(posedge pclk);
    chk("lapse", {24'h0, A_STATUS}, 32'h4, 32'h0);
    wait_st(32'h4, 32'h4);
    for (int i = 0; i < 10; i++) begin
      din_set[1] <= ~din_set[1];
      repeat (3) @(posedge pclk);
    end
    wait_st(32'h200, 32'h200);
    din_set[1] <= 1'b1;
    repeat (80) @(posedge pclk);
    chk("dis_hold", {24'h0, A_STATUS}, 32'h2, 32'h0);
    wr({24'h0, A_STATUS}, 32'h200);
    chk("dis_clr", {24'h0, A_STATUS}, 32'h200, 32'h0);
    wait_st(32'h2, 32'h2);
    // Under mode: pickup below 100, dropout above 200.
    wr({24'h0, A_PU_SP}, 32'h64);
    wr({24'h0, A_DO_SP}, 32'hc8);
    wr({24'h0, A_CTRL}, 32'h7f);
    ph_set <= {16'h01f4, 16'h0032, 16'h01f4};
    wait_st(32'h10, 32'h10);
    ph_set <= {16'h003c, 16'h0032, 16'h01f4};
    repeat (50) @(posedge pclk);
    ph_set <= {16'h003c, 16'h012c, 16'h01f4};
    repeat (100) @(posedge pclk);
    chk("one_left", {24'h0, A_STATUS}, 32'h10, 32'h10);
    ph_set <= {16'h012c, 16'h012c, 16'h01f4};
    chk("drop_wait", {24'h0, A_STATUS}, 32'h10, 32'h10);
    wait_st(32'h10, 32'h0);
    apb(1'b0, {24'h0, A_START_TS}, 32'h0, s, err);
    apb(1'b0, {24'h0, A_END_TS}, 32'h0, e, err);
    apb(1'b0, {24'h0, A_DUR}, 32'h0, d, err);
    `CHK("ts_order", 1'b1, e > s)
    `CHK("dur", e - s, d)
    `CHK("dur_min", 1'b1, d >= 32'h7)
    chk("lowest", {24'h0, A_PEAK2}, 32'hffff, 32'h32);
    chk("log_std", {24'h0, A_LOG}, 32'h7f, 32'h34);
    // Over mode: pickup above 400, dropout below 350.
    wr({24'h0, A_CTRL}, 32'h2f);
    wr({24'h0, A_PU_SP}, 32'h190);
    wr({24'h0, A_DO_SP}, 32'h15e);
    wr({24'h0, A_CTRL}, 32'h6f);
    wait_st(32'h10, 32'h10);
    ph_set <= {16'h012c, 16'h012c, 16'h0258};
    repeat (5) @(posedge pclk);
    ph_set <= {16'h012c, 16'h012c, 16'h0190};
    repeat (60) @(posedge pclk);
    chk("over_hold", {24'h0, A_STATUS}, 32'h10, 32'h10);
    ph_set <= {16'h012c, 16'h012c, 16'h012c};
    wait_st(32'h10, 32'h0);
    chk("peak", {24'h0, A_PEAK2}, 32'hffff, 32'h258);
    stop_test;
  end
endmodule // testbench
